// >>> logic/dic_pkg.sv
package dic_pkg;
   localparam logic [6:0] CFG_ADDR = 7'h01;
   localparam logic [15:0] CFG_RESET = 16'h040e;
   localparam logic [15:0] CFG_RSVD_MASK = 16'h6001;
   localparam int BIT_PATTERN_TEST = 15;
   localparam int BIT_AUTOCLEAR = 12;
   localparam int BIT_ODD_PARITY = 11;
   localparam int BIT_PARITY_EN = 10;
   localparam int BIT_DUAL_PARITY = 9;
   localparam int BIT_REV_IF = 8;
   localparam int BIT_INV_A = 7;
   localparam int BIT_INV_B = 6;
   localparam int BIT_INV_C = 5;
   localparam int BIT_INV_D = 4;
   localparam int BIT_NEAR_TWO = 3;
   localparam int BIT_NEAR_ONE = 2;
   localparam int BIT_COLLISION = 1;
   localparam logic [6:0] GOOD_SAMPLE_COUNT = 7'h40;
endpackage : dic_pkg

// >>> logic/dic_if.sv
`timescale 1ns/1ps
interface dic_chk_if;
   logic valid;
   logic [31:0] data;
   logic par_hi;
   logic par_lo;
   logic odd;
   logic dual;
   logic enable;
   logic err;
   modport src (output valid, output data, output par_hi, output par_lo, output odd, output dual, output enable,
      input err);
   modport chk (input valid, input data, input par_hi, input par_lo, input odd, input dual, input enable,
      output err);
endinterface : dic_chk_if

// >>> logic/dic_parity_check.sv
`timescale 1ns/1ps
module dic_parity_check (
   dic_chk_if.chk chk
);
   // ***********************
   // Parity compare
   // ***********************
   function automatic logic par_of(input logic [15:0] d, input logic p, input logic odd);
      par_of = (^d) ^ p ^ odd;
   endfunction : par_of

   logic single_err;
   logic dual_err;

   assign single_err = (^chk.data) ^ chk.par_hi ^ chk.odd; // see [RULE_04]
   assign dual_err = par_of(chk.data[31:16], chk.par_hi, chk.odd) | par_of(chk.data[15:0], chk.par_lo, chk.odd);
   // Dual only counts while parity is enabled
   assign chk.err = chk.valid & chk.enable & (chk.dual ? dual_err : single_err); // see [RULE_05] see [RULE_06] see [RULE_07]
endmodule : dic_parity_check

// >>> logic/dic_input_config.sv
`timescale 1ns/1ps
// Contract
// [RULE_01] Bit 15 runs the pattern checker test
// [RULE_02] Test mode forces analog outputs off
// [RULE_03] Bit 12: auto-clear alarms after 64 good
// [RULE_04] Bit 11: zero even, one odd parity
// [RULE_05] Bit 10 enables parity check, reset set
// [RULE_06] Bit 9 selects dual over single parity
// [RULE_07] Dual parity needs parity enable set
// [RULE_08] Host parity sense matches programmed sense
// [RULE_09] Bit 8 rotates strobe, sync, parity pairs
// [RULE_10] Bits 7..5 invert channels A, B, C
// [RULE_11] Channel D has its own invert bit
// [RULE_12] Channel D invert sits at bit 4
// [RULE_13] Bit 3 enables near-two FIFO alarm
// [RULE_14] Bit 2 enables near-one FIFO alarm
// [RULE_15] Bit 1 enables FIFO collision alarm
// [RULE_16] Bits 14, 13, 0 reserved, stay zero
// [RULE_17] Reset value has parity and alarms set
// [RULE_18] Any error restarts the good-sample count
module dic_input_config #(
   parameter int GOOD_RUN = int'(dic_pkg::GOOD_SAMPLE_COUNT)
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [6:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   output logic [15:0] RDATA_O,
   input wire logic SAMPLE_VALID_I,
   input wire logic [31:0] SAMPLE_I,
   input wire logic [15:0] CHAN_A_I,
   input wire logic [15:0] CHAN_B_I,
   input wire logic [15:0] CHAN_C_I,
   input wire logic [15:0] CHAN_D_I,
   input wire logic STROBE_PAIR_I,
   input wire logic SYNC_PAIR_I,
   input wire logic PARITY_PAIR_I,
   input wire logic PARITY_LO_I,
   input wire logic PATTERN_ERR_I,
   input wire logic TRANSMIT_ENABLE_PIN_I,
   input wire logic SIF_TRANSMIT_ENABLE_I,
   input wire logic FIFO_NEAR_TWO_I,
   input wire logic FIFO_NEAR_ONE_I,
   input wire logic FIFO_COLLISION_I,
   input wire logic ALARM_CLEAR_I,
   output logic [15:0] CHAN_A_O,
   output logic [15:0] CHAN_B_O,
   output logic [15:0] CHAN_C_O,
   output logic [15:0] CHAN_D_O,
   output logic STROBE_O,
   output logic SYNC_O,
   output logic PARITY_O,
   output logic PATTERN_TEST_O,
   output logic OUTPUT_ENABLE_O,
   output logic PARITY_ERR_O,
   output logic [3:0] ALARMS_O
);
   // ***********************
   // Register
   // ***********************
   logic [15:0] cfg_ff;
   logic [15:0] rdata_ff;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cfg_ff <= dic_pkg::CFG_RESET; // see [RULE_17]
      end else if (WR_I && ADDR_I == dic_pkg::CFG_ADDR) begin
         cfg_ff <= WDATA_I & ~dic_pkg::CFG_RSVD_MASK; // see [RULE_16]
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_ff <= 16'h0000;
      end else if (RD_I) begin
         rdata_ff <= (ADDR_I == dic_pkg::CFG_ADDR) ? cfg_ff : 16'h0000;
      end
   end
   assign RDATA_O = rdata_ff;

   logic test_en;
   logic autoclear_en;
   logic rev_if;
   assign test_en = cfg_ff[dic_pkg::BIT_PATTERN_TEST];
   assign autoclear_en = cfg_ff[dic_pkg::BIT_AUTOCLEAR];
   assign rev_if = cfg_ff[dic_pkg::BIT_REV_IF];

   // ***********************
   // Pin synchronisers
   // ***********************
   logic [2:0] pair_s1_ff;
   logic [2:0] pair_s2_ff;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pair_s1_ff <= 3'h0;
         pair_s2_ff <= 3'h0;
      end else begin
         pair_s1_ff <= {STROBE_PAIR_I, SYNC_PAIR_I, PARITY_PAIR_I};
         pair_s2_ff <= pair_s1_ff;
      end
   end

   logic txen_s1_ff;
   logic txen_s2_ff;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         txen_s1_ff <= 1'b0;
         txen_s2_ff <= 1'b0;
      end else begin
         txen_s1_ff <= TRANSMIT_ENABLE_PIN_I;
         txen_s2_ff <= txen_s1_ff;
      end
   end

   logic strobe_in;
   logic sync_in;
   logic parity_in;
   // Rotation: sync->strobe, parity->sync, strobe->parity
   assign strobe_in = rev_if ? pair_s2_ff[1] : pair_s2_ff[2]; // see [RULE_09]
   assign sync_in = rev_if ? pair_s2_ff[0] : pair_s2_ff[1]; // see [RULE_09]
   assign parity_in = rev_if ? pair_s2_ff[2] : pair_s2_ff[0]; // see [RULE_09]

   // ***********************
   // Parity check
   // ***********************
   dic_chk_if chk_bus();
   assign chk_bus.valid = SAMPLE_VALID_I;
   assign chk_bus.data = SAMPLE_I;
   assign chk_bus.par_hi = parity_in;
   assign chk_bus.par_lo = PARITY_LO_I;
   assign chk_bus.odd = cfg_ff[dic_pkg::BIT_ODD_PARITY]; // see [RULE_04] see [RULE_08]
   assign chk_bus.dual = cfg_ff[dic_pkg::BIT_DUAL_PARITY]; // see [RULE_06]
   assign chk_bus.enable = cfg_ff[dic_pkg::BIT_PARITY_EN]; // see [RULE_05] see [RULE_07]

   dic_parity_check u_chk (
      .chk(chk_bus)
   );

   // ***********************
   // Outputs and alarms
   // ***********************
   logic [3:0] alarms_ff;
   logic [6:0] good_cnt_ff;
   logic any_err;
   logic autoclear_hit;
   assign any_err = chk_bus.err | (test_en & PATTERN_ERR_I);
   assign autoclear_hit = autoclear_en && SAMPLE_VALID_I && !any_err && good_cnt_ff == 7'(GOOD_RUN - 1);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         good_cnt_ff <= 7'h00;
      end else if (any_err || !autoclear_en || autoclear_hit) begin
         good_cnt_ff <= 7'h00; // see [RULE_18]
      end else if (SAMPLE_VALID_I) begin
         good_cnt_ff <= good_cnt_ff + 7'h01; // see [RULE_03]
      end
   end

   logic [3:0] alarm_set;
   assign alarm_set = {any_err,
      FIFO_NEAR_TWO_I & cfg_ff[dic_pkg::BIT_NEAR_TWO], // see [RULE_13]
      FIFO_NEAR_ONE_I & cfg_ff[dic_pkg::BIT_NEAR_ONE], // see [RULE_14]
      FIFO_COLLISION_I & cfg_ff[dic_pkg::BIT_COLLISION]}; // see [RULE_15]

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         alarms_ff <= 4'h0;
      end else if (ALARM_CLEAR_I || autoclear_hit) begin
         alarms_ff <= alarm_set; // see [RULE_03]
      end else begin
         alarms_ff <= alarms_ff | alarm_set;
      end
   end
   assign ALARMS_O = alarms_ff;

   function automatic logic [15:0] flip_if(input logic [15:0] d, input logic inv);
      flip_if = inv ? ~d : d;
   endfunction : flip_if

   logic [15:0] a_ff;
   logic [15:0] b_ff;
   logic [15:0] c_ff;
   logic [15:0] d_ff;
   logic [2:0] ctl_ff;
   logic oe_ff;
   logic perr_ff;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         a_ff <= 16'h0000;
         b_ff <= 16'h0000;
         c_ff <= 16'h0000;
         d_ff <= 16'h0000;
      end else begin
         a_ff <= flip_if(CHAN_A_I, cfg_ff[dic_pkg::BIT_INV_A]); // see [RULE_10]
         b_ff <= flip_if(CHAN_B_I, cfg_ff[dic_pkg::BIT_INV_B]); // see [RULE_10]
         c_ff <= flip_if(CHAN_C_I, cfg_ff[dic_pkg::BIT_INV_C]); // see [RULE_10]
         d_ff <= flip_if(CHAN_D_I, cfg_ff[dic_pkg::BIT_INV_D]); // see [RULE_11] see [RULE_12]
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctl_ff <= 3'h0;
         oe_ff <= 1'b0;
         perr_ff <= 1'b0;
      end else begin
         ctl_ff <= {strobe_in, sync_in, parity_in};
         oe_ff <= !test_en && txen_s2_ff && SIF_TRANSMIT_ENABLE_I; // see [RULE_01] see [RULE_02]
         perr_ff <= chk_bus.err;
      end
   end

   assign CHAN_A_O = a_ff;
   assign CHAN_B_O = b_ff;
   assign CHAN_C_O = c_ff;
   assign CHAN_D_O = d_ff;
   assign STROBE_O = ctl_ff[2];
   assign SYNC_O = ctl_ff[1];
   assign PARITY_O = ctl_ff[0];
   assign PATTERN_TEST_O = test_en; // see [RULE_01]
   assign OUTPUT_ENABLE_O = oe_ff;
   assign PARITY_ERR_O = perr_ff;
endmodule : dic_input_config

// >>> verif/dic_host_model.sv
`timescale 1ns/1ps
module dic_host_model (
   input wire logic clk_i, odd_i, dual_i,
   input wire logic [1:0] bad_i,
   input wire logic [31:0] rnd_i,
   output logic valid_o, par_o, par_lo_o,
   output logic [31:0] data_o
);
   // ***
   // New word each 8 cycles, valid once pins settle
   // ***
   logic [2:0] ph_ff = 3'h0;
   initial {valid_o, par_o, par_lo_o, data_o} = 35'h0;
   always @(negedge clk_i) begin
      ph_ff <= ph_ff + 3'h1;
      valid_o <= ph_ff[2];
      if (ph_ff == 3'h0) begin
         data_o <= rnd_i;
         par_o <= odd_i ^ bad_i[1] ^ (dual_i ? ^rnd_i[31:16] : ^rnd_i);
         par_lo_o <= odd_i ^ bad_i[0] ^ (^rnd_i[15:0]);
      end
   end
endmodule : dic_host_model

// >>> verif/dic_input_config_sva.sv
`timescale 1ns/1ps
module dic_input_config_sva #(parameter int GOOD_RUN = 64) (
   input wire logic CLK_I, RST_I, WR_I, RD_I, ALARM_CLEAR_I, FIFO_COLLISION_I, PARITY_ERR_O,
   input wire logic STROBE_PAIR_I, SYNC_PAIR_I, PARITY_PAIR_I, STROBE_O, SYNC_O, PARITY_O,
   input wire logic PATTERN_TEST_O, OUTPUT_ENABLE_O, TRANSMIT_ENABLE_PIN_I, SIF_TRANSMIT_ENABLE_I,
   input wire logic [6:0] ADDR_I,
   input wire logic [3:0] ALARMS_O,
   input wire logic [15:0] WDATA_I, RDATA_O, CHAN_A_I, CHAN_B_I, CHAN_C_I, CHAN_D_I,
   input wire logic [15:0] CHAN_A_O, CHAN_B_O, CHAN_C_O, CHAN_D_O
);
   // ***
   // Shadow of the register and cycles since reset
   // ***
   logic [15:0] sh_ff;
   logic [2:0] up_ff;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sh_ff <= dic_pkg::CFG_RESET;
         up_ff <= 3'h0;
      end else begin
         if (WR_I && ADDR_I == dic_pkg::CFG_ADDR) sh_ff <= WDATA_I & ~dic_pkg::CFG_RSVD_MASK;
         if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_read_back: assert property (RD_I && !WR_I && ADDR_I == 7'h01 |=> RDATA_O == sh_ff)
      else $error("read mismatch");
   a_rsvd_zero: assert property ((RDATA_O & 16'h6001) == 16'h0000) else $error("reserved set");
   a_test_flag: assert property (PATTERN_TEST_O == sh_ff[15]) else $error("test flag");
   a_outputs_off: assert property (up_ff > 3'h3 && !$past(WR_I) |-> OUTPUT_ENABLE_O ==
      ($past(!sh_ff[15] && SIF_TRANSMIT_ENABLE_I) && $past(TRANSMIT_ENABLE_PIN_I, 3))) else $error("output enable");
   a_chan_invert: assert property (up_ff != 3'h0 && !$past(WR_I) |->
      {CHAN_A_O, CHAN_B_O, CHAN_C_O, CHAN_D_O} == $past({CHAN_A_I ^ {16{sh_ff[7]}}, CHAN_B_I ^ {16{sh_ff[6]}},
      CHAN_C_I ^ {16{sh_ff[5]}}, CHAN_D_I ^ {16{sh_ff[4]}}})) else $error("channel data");
   a_pair_rotate: assert property (up_ff > 3'h3 && !$past(WR_I) |-> {STROBE_O, SYNC_O, PARITY_O} ==
      ($past(sh_ff[8]) ? $past({SYNC_PAIR_I, PARITY_PAIR_I, STROBE_PAIR_I}, 3) :
      $past({STROBE_PAIR_I, SYNC_PAIR_I, PARITY_PAIR_I}, 3))) else $error("pair rotation");
   a_alarm_sticky: assert property (!$past(ALARM_CLEAR_I) && !sh_ff[12] && !$past(sh_ff[12]) |->
      (ALARMS_O & $past(ALARMS_O)) == $past(ALARMS_O)) else $error("alarm dropped");
   a_collision_gate: assert property ($rose(ALARMS_O[0]) |->
      $past(FIFO_COLLISION_I) && (sh_ff[1] || $past(sh_ff[1]))) else $error("collision alarm");
   a_parity_gate: assert property (PARITY_ERR_O |->
      $past(sh_ff[10]) || $past(sh_ff[10], 2) || $past(sh_ff[10], 3)) else $error("parity off");
   c_par_err: cover property (PARITY_ERR_O);
   c_test_off: cover property (PATTERN_TEST_O && !OUTPUT_ENABLE_O);
   c_alarm_fall: cover property ($fell(ALARMS_O[3]));
endmodule : dic_input_config_sva
bind dic_input_config dic_input_config_sva #(.GOOD_RUN(GOOD_RUN)) dic_input_config_sva_inst (.*);

// >>> verif/dic_input_config_tb.sv
`timescale 1ns/1ps
module dic_input_config_tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0, rnd_en = 1'b0, rd_p = 1'b0, vld, par, plo;
   logic [1:0] bad = 2'b00;
   logic [6:0] adr = 7'h01;
   logic [7:0] m = 8'h00;
   logic [3:0] al;
   logic [15:0] wd = 16'h0000, rdat, d, cur = 16'h040e;
   logic [15:0] pm[5] = '{16'h0400, 16'h0c00, 16'h0600, 16'h0e00, 16'h0200};
   logic [31:0] r = 32'h2d6f, smp;
   logic [63:0] ch = 64'h0;
   logic [15:0] exp_q[$];
   int error_cnt = 0, tests_run = 0, cyc = 0;
   always #12.5 clk = ~clk;
   // ***
   // Bus tasks and checks
   // ***
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic test_done;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic wrc(input logic [15:0] v);
      @(negedge clk);
      {wr, adr, wd, cur} = {1'b1, 7'h01, v, v};
      @(negedge clk);
      wr = 1'b0;
   endtask : wrc
   task automatic rdc(input logic [6:0] a, input logic [15:0] e);
      @(negedge clk);
      {rd, adr} = {1'b1, a};
      exp_q.push_back(e);
      @(negedge clk);
      rd = 1'b0;
   endtask : rdc
   task automatic pulse(input logic [7:0] e, input logic c);
      @(negedge clk);
      {m, clr} = {e, c};
      @(negedge clk);
      {m, clr} = 9'h000;
      repeat (8) @(negedge clk);
   endtask : pulse
   task automatic run_bad(input logic [1:0] b, input logic [15:0] e);
      bad = b;
      repeat (16) @(negedge clk);
      pulse(8'h00, 1'b1);
      repeat (16) @(negedge clk);
      chk({15'h0000, al[3]}, e);
   endtask : run_bad
   always @(negedge clk) begin
      r <= lfsr(r);
      ch <= {r, ~r};
      if (rnd_en) m <= r[7:0];
   end
   always @(posedge clk) begin
      if (rd_p) chk(rdat, exp_q.pop_front());
      rd_p <= rd;
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         test_done;
      end
   end
   dic_host_model dic_host_model_inst (.clk_i(clk), .odd_i(cur[11]), .dual_i(cur[9]), .bad_i(bad), .rnd_i(r),
      .valid_o(vld), .data_o(smp), .par_o(par), .par_lo_o(plo));
   dic_input_config #(.GOOD_RUN(4)) dic_input_config_inst (.CLK_I(clk), .RST_I(rst), .WR_I(wr), .RD_I(rd),
      .ADDR_I(adr), .WDATA_I(wd), .RDATA_O(rdat), .SAMPLE_VALID_I(vld), .SAMPLE_I(smp), .CHAN_A_I(ch[63:48]),
      .CHAN_B_I(ch[47:32]), .CHAN_C_I(ch[31:16]), .CHAN_D_I(ch[15:0]), .STROBE_PAIR_I(m[0]), .SYNC_PAIR_I(m[1]),
      .PARITY_PAIR_I(par), .PARITY_LO_I(plo), .PATTERN_ERR_I(m[4]), .TRANSMIT_ENABLE_PIN_I(m[2]),
      .SIF_TRANSMIT_ENABLE_I(m[3]), .FIFO_COLLISION_I(m[5]), .FIFO_NEAR_ONE_I(m[6]), .FIFO_NEAR_TWO_I(m[7]),
      .ALARM_CLEAR_I(clr), .CHAN_A_O(), .CHAN_B_O(), .CHAN_C_O(), .CHAN_D_O(), .STROBE_O(), .SYNC_O(),
      .PARITY_O(), .PATTERN_TEST_O(), .OUTPUT_ENABLE_O(), .PARITY_ERR_O(), .ALARMS_O(al));
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rdc(7'h01, dic_pkg::CFG_RESET);
      rdc(7'h02, 16'h0000);
      wrc(16'hffff);
      rdc(7'h01, 16'h9ffe);
      $display("Test register done");
      rnd_en = 1'b1;
      repeat (40) begin
         d = r[15:0];
         wrc(d);
         repeat (6) @(negedge clk);
         rdc(7'h01, d & 16'h9ffe);
      end
      rnd_en = 1'b0;
      @(negedge clk);
      m = 8'h00;
      $display("Test random done");
      wrc(16'h0400);
      repeat (16) @(negedge clk);
      for (int k = 0; k < 3; k++) begin
         pulse(8'h00, 1'b1);
         pulse(8'h20 << k, 1'b0);
         chk({12'h000, al}, 16'h0000);
         wrc(16'h0400 | (16'h0002 << k));
         pulse(8'h20 << k, 1'b0);
         chk({12'h000, al}, 16'h0001 << k);
         wrc(16'h0400);
      end
      $display("Test fifo done");
      foreach (pm[i]) begin
         wrc(pm[i]);
         run_bad(2'b00, 16'h0000);
         run_bad(2'b10, {15'h0000, pm[i][10]});
         run_bad(2'b01, {15'h0000, pm[i][10] & pm[i][9]});
      end
      $display("Test parity done");
      wrc(16'h1400);
      bad = 2'b10;
      repeat (24) @(negedge clk);
      chk({15'h0000, al[3]}, 16'h0001);
      bad = 2'b00;
      repeat (24) @(negedge clk);
      chk({15'h0000, al[3]}, 16'h0000);
      $display("Test autoclear done");
      test_done;
   end
endmodule : dic_input_config_tb
